// File: logic/rx_port_access_control.sv
// Port access control, reference clock supervision and equalizer relock
// Requests come decoded from the I2C target; src 0 is the local master,
// src 1..4 are accesses forwarded from remote link 0..3.
//
// What this block does
// - Per-port receiver disable bits at 0x0C
// - Only local master may write port disables
// - Page select picks port for shared address
// - Page select resets to requester's own port
// - Four programmable 7-bit direct port addresses
// - Direct addresses also reach shared registers
// - Forwarding off at reset, per-port enables
// - Strapped mode readable, overridable in 0x6D
// - Timers derived from reference clock
// - No reference edge for 20 us flags loss
// - Internal 25 MHz oscillator until reference valid
// - Tolerate spread-spectrum reference
// - Equalizer keeps monitoring while locked
// - Lock loss restarts equalizer search
// - Equalizer registers at 0xD2-0xD5
// - Per-port 40-bit or 28-bit raw format
`timescale 1ns/1ps
module rx_port_access_control #(
  parameter int N_PORTS = 4,
  parameter logic [6:0] DEV_ADDR = 7'h30, // arbitrary value
  parameter int REF_TICK_DIV = 256,
  parameter int OSC_TICK_DIV = 1024
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire rx_access_pkg::reg_req_t req,
  output rx_access_pkg::reg_rsp_t rsp,
  input wire logic [1:0] strap_mode,
  input wire logic reference_input_clock,
  input wire logic [N_PORTS-1:0] port_lock,
  input wire logic [N_PORTS-1:0] port_err,
  output logic [N_PORTS-1:0] port_rx_enable,
  output logic [N_PORTS-1:0] fwd_active,
  output rx_access_pkg::link_format_t [N_PORTS-1:0] link_input_format,
  output logic [N_PORTS-1:0][3:0] eq_setting,
  output logic ref_lost,
  output logic use_int_osc,
  output logic timer_tick
);
  import rx_access_pkg::*;

  logic [N_PORTS-1:0] rx_en_q;
  logic [7:0] fwd_ctl_q;
  logic [1:0] page_q [N_PORTS+1];
  logic [7:0] dir_q [N_PORTS];
  logic [7:0] cfg_q [N_PORTS];
  logic [7:0] eqc_q [N_PORTS];
  logic [7:0] thr_q [N_PORTS];
  logic [7:0] rng_q [N_PORTS];
  logic [3:0] eq_set_q [N_PORTS];
  eq_state_t eq_st_q [N_PORTS];
  logic [N_PORTS-1:0] eq_restart;
  logic strap_done_q;
  logic dir_hit;
  logic [1:0] dir_port;
  logic [1:0] tgt;
  logic dev_hit;
  logic we;
  logic [7:0] rdata_d;
  logic known_d;
  logic [7:0] sel_cfg;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb
  begin
    dir_hit = 1'b0;
    dir_port = 2'h0;
    for (int i = 0; i < N_PORTS; i++)
      if (dir_q[i][DIRECT_EN_BIT] && dir_q[i][6:0] == req.dev)
      begin
        dir_hit = 1'b1;
        dir_port = 2'(i);
      end
    tgt = dir_hit ? dir_port : page_q[req.src];
    dev_hit = req.valid && (dir_hit || req.dev == DEV_ADDR);
    we = dev_hit && req.write;
    sel_cfg = cfg_q[tgt];
  end

  // ----------------------------------------
  // Shared registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rx_en_q <= RST_PORT_EN;
    else if (we && req.addr == A_PORT_CTL && req.src == SRC_LOCAL)
      rx_en_q <= req.wdata[N_PORTS-1:0];
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      fwd_ctl_q <= RST_FWD;
    else if (we && req.addr == A_FWD_CTL)
      fwd_ctl_q <= req.wdata;
  end

  // Each requester owns its page; a remote link starts on its own port
  for (genvar s = 0; s <= N_PORTS; s++)
  begin : g_page
    localparam logic [1:0] PAGE_RST = (s == 0) ? 2'h0 : 2'(s - 1);
    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
        page_q[s] <= PAGE_RST;
      else if (we && req.addr == A_PAGE_SEL && req.src == 3'(s))
        page_q[s] <= req.wdata[1:0];
    end
  end

  // ----------------------------------------
  // Per-port registers and equalizer
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      strap_done_q <= 1'b0;
    else
      strap_done_q <= 1'b1;
  end

  for (genvar p = 0; p < N_PORTS; p++)
  begin : g_port
    logic pw;
    logic [8:0] dwell_q;
    logic [7:0] err_q;
    logic [8:0] limit;
    logic [3:0] floor;
    logic [3:0] eq_max;
    assign pw = we && tgt == 2'(p);
    assign limit = {eqc_q[p][7:EQ_RELOCK_LSB], 6'h3F};
    assign floor = eqc_q[p][EQ_FLOOR_EN_BIT] ? rng_q[p][3:0] : 4'h0;
    assign eq_max = rng_q[p][7:4];

    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
        dir_q[p] <= RST_DIRECT;
      else if (we && req.addr == A_DIRECT0 + 8'(p))
        dir_q[p] <= req.wdata;
    end

    // Strap taken once after release; software may then override it
    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
        cfg_q[p] <= 8'h00;
      else if (!strap_done_q)
        cfg_q[p] <= {6'h00, strap_mode};
      else if (pw && req.addr == A_PORT_CFG)
        cfg_q[p] <= req.wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
      begin
        eqc_q[p] <= RST_EQ_CTL;
        thr_q[p] <= RST_EQ_THR;
        rng_q[p] <= RST_EQ_RANGE;
      end
      else if (pw)
      begin
        // Restart is a strobe and never stored
        if (req.addr == A_EQ_CTL)
          eqc_q[p] <= req.wdata & ~8'h01;
        if (req.addr == A_EQ_THR)
          thr_q[p] <= req.wdata;
        if (req.addr == A_EQ_RANGE)
          rng_q[p] <= req.wdata;
      end
    end

    assign eq_restart[p] = (pw && req.addr == A_EQ_CTL && req.wdata[EQ_RESTART_BIT])
                           || !rx_en_q[p];

    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
      begin
        eq_st_q[p] <= EQ_SEARCH;
        eq_set_q[p] <= 4'h0;
        dwell_q <= 9'h000;
        err_q <= 8'h00;
      end
      else if (eq_restart[p] || (eq_st_q[p] == EQ_LOCKED && !port_lock[p]))
      begin
        eq_st_q[p] <= EQ_SEARCH;
        eq_set_q[p] <= floor;
        dwell_q <= 9'h000;
        err_q <= 8'h00;
      end
      else
      begin
        if (port_err[p] && err_q != 8'hFF)
          err_q <= err_q + 8'h01;
        if (timer_tick)
        begin
          dwell_q <= dwell_q + 9'h001;
          if (dwell_q == limit)
          begin
            dwell_q <= 9'h000;
            err_q <= 8'h00;
            case (eq_st_q[p])
              EQ_SEARCH:
                if (port_lock[p])
                  eq_st_q[p] <= EQ_LOCKED;
                else
                  eq_set_q[p] <= (eq_set_q[p] >= eq_max) ? floor : eq_set_q[p] + 4'h1;
              EQ_LOCKED:
                // Too many errors in a dwell window while below eq_max: step up and re-search
                if (err_q > thr_q[p] && eq_set_q[p] < eq_max)
                begin
                  eq_st_q[p] <= EQ_SEARCH;
                  eq_set_q[p] <= eq_set_q[p] + 4'h1;
                end
              default:
                eq_st_q[p] <= EQ_SEARCH;
            endcase
          end
        end
      end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
      begin
        link_input_format[p] <= FMT_PACKET40;
        eq_setting[p] <= 4'h0;
      end
      else
      begin
        link_input_format[p] <= link_format_t'(cfg_q[p][1:0]);
        eq_setting[p] <= eq_set_q[p];
      end
    end

    AST_EQ_RELOCK: assert property (@(posedge mclk) disable iff (!resetn)
      eq_st_q[p] == EQ_LOCKED && !port_lock[p] |=> eq_st_q[p] == EQ_SEARCH
      && eq_set_q[p] == $past(floor))
      else $error("equalizer did not restart on lock loss");
    COV_EQ_LOCK: cover property (@(posedge mclk) disable iff (!resetn)
      $rose(eq_st_q[p] == EQ_LOCKED));
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    known_d = 1'b1;
    case (req.addr)
      A_PORT_CTL: rdata_d = 8'(rx_en_q);
      A_FWD_CTL: rdata_d = fwd_ctl_q;
      A_PAGE_SEL: rdata_d = {6'h00, page_q[req.src]};
      A_PORT_CFG: rdata_d = sel_cfg;
      A_EQ_CTL: rdata_d = eqc_q[tgt];
      A_EQ_STAT: rdata_d = {eq_st_q[tgt], 3'h0, eq_set_q[tgt]};
      A_EQ_THR: rdata_d = thr_q[tgt];
      A_EQ_RANGE: rdata_d = rng_q[tgt];
      default:
      begin
        rdata_d = 8'h00;
        known_d = req.addr >= A_DIRECT0 && req.addr <= A_DIRECT3;
        if (known_d)
          rdata_d = dir_q[2'(req.addr - A_DIRECT0)];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rsp <= '0;
    else
    begin
      rsp.valid <= req.valid;
      rsp.hit <= dev_hit && known_d;
      rsp.rdata <= (dev_hit && !req.write) ? rdata_d : 8'h00;
    end
  end

  // ----------------------------------------
  // Reference clock supervision
  // ----------------------------------------
  logic ref_q;
  logic ref_edge;
  logic ref_rise;
  logic [11:0] gap_q;
  logic [5:0] win_edges_q;
  logic [8:0] win_cyc_q;
  logic ref_ok_q;
  logic [9:0] ref_div_q;
  logic [10:0] osc_div_q;

  assign ref_edge = reference_input_clock != ref_q;
  assign ref_rise = reference_input_clock && !ref_q;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_q <= 1'b0;
      gap_q <= 12'h000;
      ref_lost <= 1'b1;
    end
    else
    begin
      ref_q <= reference_input_clock;
      gap_q <= ref_edge ? 12'h000 : (ref_lost ? gap_q : gap_q + 12'h001);
      if (ref_edge)
        ref_lost <= 1'b0;
      else if (gap_q == 12'(REF_LOSS_CYC))
        ref_lost <= 1'b1;
    end
  end

  // Window bounds are wide enough that spread-spectrum modulation never
  // drops the reference, at the cost of coarse frequency checking
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      win_edges_q <= 6'h00;
      win_cyc_q <= 9'h000;
      ref_ok_q <= 1'b0;
    end
    else if (ref_lost)
    begin
      win_edges_q <= 6'h00;
      win_cyc_q <= 9'h000;
      ref_ok_q <= 1'b0;
    end
    else
    begin
      win_cyc_q <= (win_cyc_q == 9'h1FF) ? win_cyc_q : win_cyc_q + 9'h001;
      if (ref_rise)
      begin
        win_edges_q <= win_edges_q + 6'h01;
        if (win_edges_q == REF_WIN_LAST)
        begin
          ref_ok_q <= win_cyc_q >= REF_WIN_MIN && win_cyc_q <= REF_WIN_MAX;
          win_cyc_q <= 9'h000;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      use_int_osc <= 1'b1;
    else
      use_int_osc <= !ref_ok_q || ref_lost;
  end

  // Timer base: reference edges when valid, else the backup oscillator rate
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_div_q <= 10'h000;
      osc_div_q <= 11'h000;
      timer_tick <= 1'b0;
    end
    else
    begin
      timer_tick <= 1'b0;
      if (!use_int_osc)
      begin
        osc_div_q <= 11'h000;
        if (ref_rise)
        begin
          ref_div_q <= ref_div_q + 10'h001;
          if (ref_div_q == 10'(REF_TICK_DIV - 1))
          begin
            ref_div_q <= 10'h000;
            timer_tick <= 1'b1;
          end
        end
      end
      else
      begin
        ref_div_q <= 10'h000;
        osc_div_q <= osc_div_q + 11'h001;
        if (osc_div_q == 11'(OSC_TICK_DIV - 1))
        begin
          osc_div_q <= 11'h000;
          timer_tick <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_rx_enable <= '0;
      fwd_active <= '0;
    end
    else
    begin
      port_rx_enable <= rx_en_q;
      fwd_active <= fwd_ctl_q[N_PORTS-1:0] & rx_en_q;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_PORT_CTL_LOCAL: assert property (@(posedge mclk) disable iff (!resetn)
    we && req.addr == A_PORT_CTL && req.src == SRC_LOCAL
    |=> ##1 port_rx_enable == $past(req.wdata[N_PORTS-1:0], 2))
    else $error("local port control write not applied");
  AST_PORT_CTL_REMOTE: assert property (@(posedge mclk) disable iff (!resetn)
    req.valid && req.write && req.src != SRC_LOCAL |=> $stable(rx_en_q))
    else $error("remote access changed port disables");
  AST_PAGE_DEFAULT: assert property (@(posedge mclk) disable iff (!resetn)
    !$past(resetn) |-> page_q[0] == 2'h0 && page_q[3] == 2'h2)
    else $error("page select reset value wrong");
  AST_PAGE_TARGET: assert property (@(posedge mclk) disable iff (!resetn)
    req.valid && !req.write && req.dev == DEV_ADDR && !dir_hit
    && req.addr == A_PORT_CFG |=> rsp.rdata == $past(sel_cfg))
    else $error("paged read returned wrong port");
  AST_DIRECT_SHARED: assert property (@(posedge mclk) disable iff (!resetn)
    dir_hit && req.valid && !req.write && req.addr == A_FWD_CTL
    |=> rsp.hit && rsp.rdata == $past(fwd_ctl_q))
    else $error("direct address missed shared register");
  AST_FWD_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (fwd_active & ~$past(fwd_ctl_q[N_PORTS-1:0])) == '0)
    else $error("forwarding without enable");
  AST_STRAP: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(strap_done_q) |=> cfg_q[0][1:0] == $past(strap_mode, 2))
    else $error("strap mode not captured");
  AST_REF_LOSS: assert property (@(posedge mclk) disable iff (!resetn)
    gap_q == 12'(REF_LOSS_CYC) && !ref_edge |=> ref_lost ##1 use_int_osc)
    else $error("reference loss not flagged");
  COV_REMOTE_WRITE: cover property (@(posedge mclk) disable iff (!resetn)
    req.valid && req.write && req.src != SRC_LOCAL && req.addr == A_PORT_CTL);
  COV_REF_GOOD: cover property (@(posedge mclk) disable iff (!resetn)
    $fell(use_int_osc));
  COV_DIRECT: cover property (@(posedge mclk) disable iff (!resetn)
    dev_hit && dir_hit);
endmodule

// File: inc/rx_access_pkg.sv
// Register map, reset values, field positions and timing counts
// Assumes a 100 MHz mclk and byte-wide registers.
package rx_access_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] A_PORT_CTL = 8'h0C;
  localparam logic [7:0] A_FWD_CTL = 8'h20;
  localparam logic [7:0] A_PAGE_SEL = 8'h4C;
  localparam logic [7:0] A_PORT_CFG = 8'h6D;
  localparam logic [7:0] A_EQ_CTL = 8'hD2;
  localparam logic [7:0] A_EQ_STAT = 8'hD3;
  localparam logic [7:0] A_EQ_THR = 8'hD4;
  localparam logic [7:0] A_EQ_RANGE = 8'hD5;
  localparam logic [7:0] A_DIRECT0 = 8'hF8;
  localparam logic [7:0] A_DIRECT3 = 8'hFB;
  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [3:0] RST_PORT_EN = 4'hF;
  localparam logic [7:0] RST_FWD = 8'h00;
  localparam logic [7:0] RST_EQ_CTL = 8'h60;
  localparam logic [7:0] RST_EQ_THR = 8'h10;
  localparam logic [7:0] RST_EQ_RANGE = 8'hF0;
  localparam logic [7:0] RST_DIRECT = 8'h00;
  localparam int EQ_RESTART_BIT = 0;
  localparam int EQ_FLOOR_EN_BIT = 2;
  localparam int EQ_RELOCK_LSB = 5;
  localparam int DIRECT_EN_BIT = 7;
  localparam logic [2:0] SRC_LOCAL = 3'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_LOSS_NS = 20000;
  localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_PERIOD_NS;
  localparam logic [5:0] REF_WIN_LAST = 6'h3F;
  // 64 reference edges: 23 MHz with 1% down spread .. 26 MHz +0.5%
  localparam logic [8:0] REF_WIN_MIN = 9'h0F4;
  localparam logic [8:0] REF_WIN_MAX = 9'h11A;

  typedef enum logic [1:0] {
    FMT_PACKET40 = 2'b00,
    FMT_RAW12_LF = 2'b01,
    FMT_RAW12_HF = 2'b10,
    FMT_RAW10 = 2'b11
  } link_format_t;

  typedef enum logic {
    EQ_SEARCH = 1'b0,
    EQ_LOCKED = 1'b1
  } eq_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] src;
    logic [6:0] dev;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] rdata;
  } reg_rsp_t;
endpackage

// File: sim/ref_clock_source.sv
// Reference clock source model standing on the far side of the reference pin
// Assumes the bench gates it through run; the line stands still while stopped.
`timescale 1ns/1ps
module ref_clock_source #(
  parameter real HALF_NS = 20.0
) (
  input wire logic run,
  output logic reference_input_clock
);
  // ----------------------------------------
  // Clock generation
  // ----------------------------------------
  // Nominal 25 MHz, inside the accepted band; holds its level when stopped
  // so the device sees a genuine loss of transitions, not a slow clock
  initial
  begin
    reference_input_clock = 1'b0;
    forever
    begin
      #(HALF_NS);
      if (run)
      begin
        reference_input_clock = ~reference_input_clock;
      end
    end
  end
endmodule

// File: sim/rx_port_access_control_tb.sv
// Self-checking bench for the port access control block
// Assumes the design package is compiled first and the reference model in sim/.
`timescale 1ns/1ps
module rx_port_access_control_tb;
  import rx_access_pkg::*;
  typedef struct packed {
    logic hit;
    logic [7:0] data;
    logic [7:0] mask;
  } exp_t;
  localparam logic [6:0] DEV = 7'h30;
  logic mclk;
  logic resetn;
  reg_req_t req;
  reg_rsp_t rsp;
  logic [1:0] strap_mode;
  logic reference_input_clock;
  logic ref_run;
  logic [3:0] port_lock;
  logic [3:0] port_err;
  logic [3:0] port_rx_enable;
  logic [3:0] fwd_active;
  link_format_t [3:0] link_input_format;
  logic [3:0][3:0] eq_setting;
  logic ref_lost;
  logic use_int_osc;
  logic timer_tick;
  exp_t exp_q[$];
  int num_errors;
  int samples_checked;
  int seed;
  int n;
  logic [6:0] dir_addr;

  rx_port_access_control #(.DEV_ADDR(DEV), .REF_TICK_DIV(4), .OSC_TICK_DIV(8))
    u_rx_port_access_control (
    .mclk(mclk), .resetn(resetn), .req(req), .rsp(rsp), .strap_mode(strap_mode),
    .reference_input_clock(reference_input_clock), .port_lock(port_lock),
    .port_err(port_err), .port_rx_enable(port_rx_enable), .fwd_active(fwd_active),
    .link_input_format(link_input_format), .eq_setting(eq_setting),
    .ref_lost(ref_lost), .use_int_osc(use_int_osc), .timer_tick(timer_tick));

  ref_clock_source u_ref_clock_source (.run(ref_run),
    .reference_input_clock(reference_input_clock));

  // ----------------------------------------
  // Reporting and comparison
  // ----------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic check_lvl(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fail($sformatf("%s got %h expected %h", what, got, exp));
    end
  endtask

  task automatic cmp_rsp(input exp_t e);
    samples_checked++;
    if (rsp.hit !== e.hit || (rsp.rdata & e.mask) !== (e.data & e.mask))
    begin
      fail($sformatf("response hit %b data %h expected %b %h", rsp.hit, rsp.rdata,
        e.hit, e.data));
    end
  endtask

  // Responses arrive one cycle after each request, in request order
  always @(posedge mclk)
  begin
    if (rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        fail("response with nothing outstanding");
      end
      else
      begin
        cmp_rsp(exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------
  // Register bus driving
  // ----------------------------------------
  function automatic exp_t ex(input logic h, input logic [7:0] d, input logic [7:0] m);
    return '{hit: h, data: d, mask: m};
  endfunction

  // Leaves valid up so calls can run back to back; idle drops it
  task automatic acc(input logic wr, input logic [2:0] src, input logic [6:0] dev,
                     input logic [7:0] addr, input logic [7:0] wd, input exp_t e);
    req = '{valid: 1'b1, write: wr, src: src, dev: dev, addr: addr, wdata: wd};
    exp_q.push_back(e);
    @(posedge mclk);
    #1;
  endtask

  task automatic idle(input int cyc);
    req.valid = 1'b0;
    repeat (cyc)
    begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] d);
    acc(1'b1, SRC_LOCAL, DEV, addr, d, ex(1'b1, 8'h00, 8'hff));
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] d, input logic [7:0] m);
    acc(1'b0, SRC_LOCAL, DEV, addr, 8'h00, ex(1'b1, d, m));
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever
    begin
      #5 mclk = ~mclk;
    end
  end

  initial
  begin
    #500_000;
    fail("run did not finish in time");
    end_sim();
  end

  initial
  begin
    seed = 32'he923_29ca;
    num_errors = 0;
    samples_checked = 0;
    resetn = 1'b0;
    req = '0;
    port_lock = 4'h0;
    port_err = 4'h0;
    ref_run = 1'b1;
    strap_mode = 2'($random(seed));
    dir_addr = {1'b1, 6'($random(seed))};
    repeat (2) @(posedge mclk);
    #1;
    check_lvl({7'h0, use_int_osc}, 8'h01, "backup osc in reset");
    check_lvl({7'h0, ref_lost}, 8'h01, "loss flag in reset");
    check_lvl({4'h0, fwd_active}, 8'h00, "forwarding in reset");
    resetn = 1'b1;
    idle(2);
    rd(A_PORT_CTL, {4'h0, RST_PORT_EN}, 8'hff);
    rd(A_FWD_CTL, RST_FWD, 8'hff);
    rd(A_PAGE_SEL, 8'h00, 8'h03);
    acc(1'b0, 3'h3, DEV, A_PAGE_SEL, 8'h00, ex(1'b1, 8'h02, 8'h03));
    rd(A_EQ_CTL, RST_EQ_CTL, 8'hff);
    rd(A_EQ_THR, RST_EQ_THR, 8'hff);
    rd(A_EQ_RANGE, RST_EQ_RANGE, 8'hff);
    rd(A_DIRECT0, RST_DIRECT, 8'hff);
    rd(A_PORT_CFG, {6'h0, strap_mode}, 8'h03);
    acc(1'b0, SRC_LOCAL, DEV, 8'h7f, 8'h00, ex(1'b0, 8'h00, 8'hff));
    acc(1'b0, SRC_LOCAL, 7'h11, A_FWD_CTL, 8'h00, ex(1'b0, 8'h00, 8'hff));
    idle(1);
    check_lvl({6'h0, link_input_format[0]}, {6'h0, strap_mode}, "strapped format");
    $display("test reset_values done");

    acc(1'b1, 3'h1, DEV, A_PORT_CTL, 8'h00, ex(1'b1, 8'h00, 8'hff));
    rd(A_PORT_CTL, 8'h0f, 8'hff);
    wr(A_PORT_CTL, 8'h05);
    rd(A_PORT_CTL, 8'h05, 8'hff);
    idle(2);
    check_lvl({4'h0, port_rx_enable}, 8'h05, "port enables");
    check_lvl({4'h0, fwd_active}, 8'h00, "forwarding before enable");
    wr(A_FWD_CTL, 8'h0f);
    idle(3);
    check_lvl({4'h0, fwd_active}, 8'h05, "forwarding active");
    $display("test port_control done");

    wr(A_PAGE_SEL, 8'h02);
    for (n = 3; n >= 0; n--)
    begin
      wr(A_PORT_CFG, 8'(n));
      idle(2);
      check_lvl({6'h0, link_input_format[2]}, 8'(n), "paged format");
    end
    check_lvl({6'h0, link_input_format[0]}, {6'h0, strap_mode}, "other page kept");
    $display("test paging done");

    wr(A_DIRECT0 + 8'h01, {1'b1, dir_addr});
    acc(1'b1, SRC_LOCAL, dir_addr, A_PORT_CFG, 8'h02, ex(1'b1, 8'h00, 8'hff));
    acc(1'b0, SRC_LOCAL, dir_addr, A_FWD_CTL, 8'h00, ex(1'b1, 8'h0f, 8'hff));
    rd(A_DIRECT0 + 8'h01, {1'b1, dir_addr}, 8'hff);
    idle(2);
    check_lvl({6'h0, link_input_format[1]}, 8'h02, "direct format");
    wr(A_DIRECT0 + 8'h01, 8'h00);
    acc(1'b0, SRC_LOCAL, dir_addr, A_FWD_CTL, 8'h00, ex(1'b0, 8'h00, 8'hff));
    idle(1);
    $display("test direct_address done");

    idle(400);
    check_lvl({7'h0, ref_lost}, 8'h00, "reference present");
    check_lvl({7'h0, use_int_osc}, 8'h00, "on external reference");
    n = 0;
    repeat (320)
    begin
      @(posedge mclk);
      #1;
      n += int'(timer_tick === 1'b1);
    end
    check_lvl({7'h0, n >= 19 && n <= 21}, 8'h01, "ticks from reference");
    $display("test reference_timer done");

    port_lock = 4'hf;
    wr(A_PAGE_SEL, 8'h00);
    wr(A_EQ_CTL, 8'h01);
    idle(5200);
    rd(A_EQ_STAT, 8'h80, 8'h80);
    idle(1100);
    rd(A_EQ_STAT, 8'h80, 8'h80);
    idle(1);
    // Steady errors while locked must push the setting up by exactly one
    port_err[0] = 1'b1;
    n = 0;
    while (eq_setting[0] === 4'h0 && n < 2100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    port_err[0] = 1'b0;
    if (n >= 2100)
    begin
      fail("equalizer ignored errors");
      end_sim();
    end
    check_lvl({4'h0, eq_setting[0]}, 8'h01, "step up on errors");
    idle(1100);
    rd(A_EQ_STAT, 8'h81, 8'h8f);
    port_lock[0] = 1'b0;
    idle(2);
    rd(A_EQ_STAT, 8'h00, 8'h8f);
    idle(1);
    check_lvl({4'h0, eq_setting[0]}, 8'h00, "equalizer back at floor");
    $display("test equalizer done");

    ref_run = 1'b0;
    n = 0;
    while (ref_lost !== 1'b1 && n < 2100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 2100)
    begin
      fail("loss flag never set");
      end_sim();
    end
    check_lvl({7'h0, n >= 1995 && n <= 2004}, 8'h01, "loss delay");
    idle(1);
    check_lvl({7'h0, use_int_osc}, 8'h01, "fallback to backup osc");
    ref_run = 1'b1;
    idle(10);
    check_lvl({7'h0, ref_lost}, 8'h00, "loss cleared");
    $display("test reference_loss done");

    idle(2);
    if (exp_q.size() != 0)
    begin
      fail("responses missing");
    end
    end_sim();
  end
endmodule
